// [dv/amp_mode_control_bench.sv]
// self-checking bench for the amplifier mode controller
`timescale 1ns/1ps
module amp_mode_control_bench;
    import amp_mode_pkg::*;
    localparam int TO = 50;
    logic        ref_clk = 0, rstn = 0, sel = 0, run_req = 1, en_n = 0, temp = 0;
    logic        wr = 0, rd = 0, run, beep, lowc, brid, se, bact, irq;
    logic [1:0]  addr = 0, src;
    logic [7:0]  wdata = 0, rdata, gain;
    out_enable_s oe;
    int          errors = 0, total_checks = 0, vol = 0, st_m = 0;

    always #2 ref_clk = ~ref_clk;

    beep_source beep_source_inst (.ref_clk(ref_clk), .run_req(run_req), .run(run),
        .beep_input(beep));
    amp_mode_control #(.TIMEOUT_CYCLES(TO)) amp_mode_control_inst (
        .ref_clk(ref_clk), .rstn(rstn), .output_config_select(sel), .run(run),
        .beep_input(beep), .beep_detect_enable_n(en_n), .over_temp(temp),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .out_enable(oe), .source_select(src), .gain_code(gain), .low_current(lowc),
        .bridged_mode(brid), .single_ended_mode(se), .beep_active(bact), .irq(irq));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    // pins pass two sync stages and an output stage
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_beep(input logic lvl);
        int n;
        n = 0;
        while (bact !== lvl && n < 200) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk({7'h0, bact}, {7'h0, lvl});
        st_m = st_m | (lvl ? 1 : 2);
        settle();
    endtask

    // reference model of the outputs from pin levels and beep state
    task automatic chk_out(input logic b);
        logic [3:0] eo;
        logic [1:0] es;
        eo = temp ? 4'h0 : b ? 4'hF : !run_req ? 4'h0 : sel ? 4'hC : 4'hF;
        es = b ? SRC_BEEP : sel ? SRC_HEADPHONE : SRC_LINE;
        chk({4'h0, oe}, {4'h0, eo});
        chk({7'h0, lowc}, {7'h0, !run_req && !b});
        chk({7'h0, irq}, {7'h0, |(st_m[2:0] & 3'h7)});
        if (b || (run_req && !temp)) begin
            chk({6'h0, src}, {6'h0, es});
            chk(gain, b ? BEEP_GAIN_TENTHS : vol[7:0]);
            chk({6'h0, brid, se}, {6'h0, b | !sel, !b & sel});
        end
        rd_reg(ADDR_MODE, {3'h0, temp, b, run_req, sel, !sel});
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h0dbd0252));
        repeat (11) @(posedge ref_clk);
        #1 chk({4'h0, oe}, 8'h00);
        chk({7'h0, lowc}, 8'h01);
        @(posedge ref_clk);
        rstn <= 1'b1;
        settle();
        rd_reg(ADDR_STATUS, 8'h00);
        rd_reg(ADDR_MASK, {5'h0, MASK_RESET});
        rd_reg(ADDR_VOLUME, {3'h0, VOLUME_RESET});
        wr_reg(ADDR_MASK, 8'h07);
        // mode register is read-only, this write must vanish
        wr_reg(ADDR_MODE, 8'hFF);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            vol = $urandom & 31;
            wr_reg(ADDR_VOLUME, vol[7:0]);
            rd_reg(ADDR_VOLUME, vol[7:0]);
            @(posedge ref_clk);
            sel <= i[0];
            run_req <= i[1] | i[2];
            settle();
            chk_out(1'b0);
        end
        $display("test mode table done");
        @(posedge ref_clk);
        sel <= 1'b1;
        run_req <= 1'b1;
        beep_source_inst.send(7);
        settle();
        chk_out(1'b0);
        repeat (TO + 10) @(posedge ref_clk);
        beep_source_inst.send(1);
        settle();
        chk_out(1'b0);
        repeat (TO + 10) @(posedge ref_clk);
        beep_source_inst.send(8);
        wait_beep(1'b1);
        chk_out(1'b1);
        wait_beep(1'b0);
        chk_out(1'b0);
        rd_reg(ADDR_STATUS, st_m[7:0]);
        wr_reg(ADDR_STATUS, 8'h01);
        st_m = 2;
        rd_reg(ADDR_STATUS, 8'h02);
        $display("test beep done");
        @(posedge ref_clk);
        run_req <= 1'b0;
        repeat (TO) @(posedge ref_clk);
        beep_source_inst.send(8);
        wait_beep(1'b1);
        chk_out(1'b1);
        wait_beep(1'b0);
        chk_out(1'b0);
        $display("test beep wake done");
        @(posedge ref_clk);
        en_n <= 1'b1;
        run_req <= 1'b1;
        beep_source_inst.send(8);
        settle();
        chk_out(1'b0);
        @(posedge ref_clk);
        en_n <= 1'b0;
        repeat (TO + 10) @(posedge ref_clk);
        beep_source_inst.send(8);
        wait_beep(1'b1);
        // raising the enable mid-beep must end it long before the silence timeout
        @(posedge ref_clk);
        en_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 chk({7'h0, bact}, 8'h00);
        wait_beep(1'b0);
        chk_out(1'b0);
        @(posedge ref_clk);
        en_n <= 1'b0;
        repeat (TO + 10) @(posedge ref_clk);
        $display("test beep disabled done");
        @(posedge ref_clk);
        temp <= 1'b1;
        settle();
        st_m = st_m | 4;
        chk_out(1'b0);
        wr_reg(ADDR_MASK, 8'h00);
        #1 chk({7'h0, irq}, 8'h00);
        wr_reg(ADDR_STATUS, 8'h07);
        st_m = 0;
        rd_reg(ADDR_STATUS, 8'h00);
        wr_reg(ADDR_MASK, 8'h07);
        temp <= 1'b0;
        settle();
        chk_out(1'b0);
        $display("test over temperature done");
        // reset in mid-run: outputs fall back, registers return to their reset values
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk({4'h0, oe}, 8'h00);
        chk({6'h0, src}, {6'h0, SRC_NONE});
        chk({7'h0, lowc}, 8'h01);
        chk(gain, 8'h00);
        @(posedge ref_clk);
        rstn <= 1'b1;
        vol = int'(VOLUME_RESET);
        settle();
        rd_reg(ADDR_MASK, {5'h0, MASK_RESET});
        rd_reg(ADDR_STATUS, 8'h00);
        wr_reg(ADDR_MASK, 8'h07);
        chk_out(1'b0);
        $display("test reset in run done");
        end_of_test();
    end
endmodule

// [dv/beep_source.sv]
// far-side pin source: run level and beep pulse train
`timescale 1ns/1ps
module beep_source (
    input  wire logic ref_clk,
    input  wire logic run_req,
    output logic      run,
    output logic      beep_input
);
    // one procedural driver for the pin; the task below is its only writer
    logic beep_reg = 1'b0;

    assign run = run_req;
    assign beep_input = beep_reg;

    // four cycles high, five low, rests low between trains
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            beep_reg <= 1'b1;
            repeat (4) @(posedge ref_clk);
            beep_reg <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask
endmodule

// [hw/amp_mode_control.sv]
// mode, input selection, beep override and thermal shutdown control of a stereo amplifier
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

// Contract
// - select low enables both inverting amplifiers, bridged drive.
// - select high puts inverting amplifiers in high impedance, single-ended.
// - bridged mode routes the line source pair.
// - single-ended mode routes the headphone source pair.
// - run low mutes all outputs and enters low current state.
// - beep active deselects both pairs and drives bridged from beep input.
// - beep path uses fixed gain, ignoring volume.
// - after beep, previous mode and volume return unchanged.
// - beep in low power wakes, plays, then returns to low power.
// - beep switching only while detect enable is low and beep valid.
// - beep valid after at least eight rising edges.
// - over-temperature turns outputs off.
module amp_mode_control
    import amp_mode_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = BEEP_TIMEOUT_CYCLES
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              output_config_select,
    input  wire logic              run,
    input  wire logic              beep_input,
    input  wire logic              beep_detect_enable_n,
    input  wire logic              over_temp,
    input  wire logic [1:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    output out_enable_s            out_enable,
    output logic      [1:0]        source_select,
    output logic      [7:0]        gain_code,
    output logic                   low_current,
    output logic                   bridged_mode,
    output logic                   single_ended_mode,
    output logic                   beep_active,
    output logic                   irq
);

    // two-stage synchronisers for pin inputs: bit order sel, run, beep, en_n, temp
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync_next;

    always_comb begin
        sync_next = {output_config_select, run, beep_input, beep_detect_enable_n, over_temp};
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 5'h02;
            sync2_reg <= 5'h02;
        end else begin
            sync1_reg <= sync_next;
            sync2_reg <= sync1_reg;
        end
    end

    logic sel_s;
    logic run_s;
    logic beep_s;
    logic en_n_s;
    logic temp_s;
    assign {sel_s, run_s, beep_s, en_n_s, temp_s} = sync2_reg;

    // beep detector
    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

    beep_state_e    state_reg;
    beep_state_e    state_next;
    logic [3:0]     edges_reg;
    logic [3:0]     edges_next;
    logic [TW-1:0]  idle_reg;
    logic [TW-1:0]  idle_next;
    logic           beep_prev_reg;
    logic           rise;
    logic           timeout;

    assign rise    = beep_s && !beep_prev_reg;
    assign timeout = (idle_reg == TW'(TIMEOUT_CYCLES - 1));

    always_comb begin
        state_next = state_reg;
        edges_next = edges_reg;
        idle_next  = rise ? '0 : (timeout ? idle_reg : idle_reg + TW'(1));
        case (state_reg)
            ST_IDLE: begin
                edges_next = 4'h0;
                if (rise && !en_n_s) begin
                    edges_next = 4'h1;
                    state_next = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (timeout || en_n_s) begin
                    edges_next = 4'h0;
                    state_next = ST_IDLE;
                end else if (rise) begin
                    edges_next = edges_reg + 4'h1;
                    if (edges_reg + 4'h1 >= BEEP_MIN_EDGES) begin
                        state_next = ST_BEEP;
                    end
                end
            end
            ST_BEEP: begin
                if (timeout || en_n_s) begin
                    edges_next = 4'h0;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                edges_next = 4'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg     <= ST_IDLE;
            edges_reg     <= 4'h0;
            idle_reg      <= '0;
            beep_prev_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            edges_reg     <= edges_next;
            idle_reg      <= idle_next;
            beep_prev_reg <= beep_s;
        end
    end

    logic beep_on;
    assign beep_on = (state_reg == ST_BEEP);

    // registers: volume and mode are never touched by the beep, so they restore themselves
    logic [2:0] status_reg;
    logic [2:0] status_next;
    logic [2:0] mask_reg;
    logic [2:0] mask_next;
    logic [4:0] volume_reg;
    logic [4:0] volume_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       temp_prev_reg;
    logic [2:0] events;

    assign events[IRQ_BEEP_START] = (state_next == ST_BEEP) && !beep_on;
    assign events[IRQ_BEEP_END]   = beep_on && (state_next != ST_BEEP);
    assign events[IRQ_OVERTEMP]   = temp_s && !temp_prev_reg;

    always_comb begin
        mask_next   = mask_reg;
        volume_next = volume_reg;
        status_next = status_reg;
        rdata_next  = 8'h00;
        if (reg_wr && reg_addr == ADDR_STATUS) begin
            status_next = status_reg & ~reg_wdata[2:0];
        end else if (reg_wr && reg_addr == ADDR_MASK) begin
            mask_next = reg_wdata[2:0];
        end else if (reg_wr && reg_addr == ADDR_VOLUME) begin
            volume_next = reg_wdata[4:0];
        end
        // a new event wins over a clear in the same cycle
        status_next = status_next | events;
        if (reg_rd && reg_addr == ADDR_STATUS) begin
            rdata_next = {5'h00, status_reg};
        end else if (reg_rd && reg_addr == ADDR_MASK) begin
            rdata_next = {5'h00, mask_reg};
        end else if (reg_rd && reg_addr == ADDR_MODE) begin
            rdata_next = {3'h0, temp_s, beep_on, run_s, sel_s, ~sel_s};
        end else if (reg_rd && reg_addr == ADDR_VOLUME) begin
            rdata_next = {3'h0, volume_reg};
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status_reg    <= 3'h0;
            mask_reg      <= MASK_RESET;
            volume_reg    <= VOLUME_RESET;
            rdata_reg     <= 8'h00;
            temp_prev_reg <= 1'b0;
        end else begin
            status_reg    <= status_next;
            mask_reg      <= mask_next;
            volume_reg    <= volume_next;
            rdata_reg     <= rdata_next;
            temp_prev_reg <= temp_s;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq       = |(status_reg & mask_reg);

    // output decision, registered
    out_enable_s oe_next;
    out_enable_s oe_reg;
    logic [1:0]  src_next;
    logic [1:0]  src_reg;
    logic [7:0]  gain_next;
    logic [7:0]  gain_reg;
    logic        lowc_next;
    logic        lowc_reg;

    always_comb begin
        oe_next   = '0;
        src_next  = SRC_NONE;
        gain_next = {3'h0, volume_reg};
        lowc_next = 1'b0;
        if (temp_s) begin
            lowc_next = !run_s;
        end else if (beep_on) begin
            oe_next   = '{1'b1, 1'b1, 1'b1, 1'b1};
            src_next  = SRC_BEEP;
            gain_next = BEEP_GAIN_TENTHS;
        end else if (!run_s) begin
            // volume and mode resume from untouched state
            lowc_next = 1'b1;
        end else if (!sel_s) begin
            oe_next  = '{1'b1, 1'b1, 1'b1, 1'b1};
            src_next = SRC_LINE;
        end else begin
            oe_next  = '{1'b1, 1'b1, 1'b0, 1'b0};
            src_next = SRC_HEADPHONE;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            oe_reg   <= '0;
            src_reg  <= SRC_NONE;
            gain_reg <= 8'h00;
            lowc_reg <= 1'b1;
        end else begin
            oe_reg   <= oe_next;
            src_reg  <= src_next;
            gain_reg <= gain_next;
            lowc_reg <= lowc_next;
        end
    end

    assign out_enable        = oe_reg;
    assign source_select     = src_reg;
    assign gain_code         = gain_reg;
    assign low_current       = lowc_reg;
    assign beep_active       = (src_reg == SRC_BEEP);
    assign bridged_mode      = oe_reg.left_inverting_output;
    assign single_ended_mode = oe_reg.left_noninverting_output && !oe_reg.left_inverting_output;

    // assertions
    property p_bridged;
        @(posedge ref_clk) disable iff (!rstn)
        (!sel_s && run_s && !temp_s && !beep_on) |=> (out_enable == 4'hF && source_select == SRC_LINE);
    endproperty
    a_bridged: assert property (p_bridged) else $error("bridged mode not applied");

    property p_single;
        @(posedge ref_clk) disable iff (!rstn)
        (sel_s && run_s && !temp_s && !beep_on) |=> (out_enable == 4'hC && source_select == SRC_HEADPHONE);
    endproperty
    a_single: assert property (p_single) else $error("single-ended mode not applied");

    property p_mute;
        @(posedge ref_clk) disable iff (!rstn)
        (!run_s && !beep_on) |=> (out_enable == 4'h0 && low_current);
    endproperty
    a_mute: assert property (p_mute) else $error("run low did not mute");

    property p_beep_drive;
        @(posedge ref_clk) disable iff (!rstn)
        (beep_on && !temp_s) |=> (source_select == SRC_BEEP && out_enable == 4'hF && !low_current);
    endproperty
    a_beep_drive: assert property (p_beep_drive) else $error("beep path not driven");

    property p_beep_gain;
        @(posedge ref_clk) disable iff (!rstn)
        beep_active |-> gain_code == BEEP_GAIN_TENTHS;
    endproperty
    a_beep_gain: assert property (p_beep_gain) else $error("beep gain not fixed");

    property p_restore;
        @(posedge ref_clk) disable iff (!rstn)
        (beep_on ##1 (!beep_on && run_s && !temp_s && !reg_wr)) |=> gain_code == {3'h0, volume_reg};
    endproperty
    a_restore: assert property (p_restore) else $error("volume not restored after beep");

    property p_enable_gate;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(beep_on) |-> $past(!en_n_s) && $past(edges_reg) == BEEP_MIN_EDGES - 4'h1;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("beep switched without eight edges");

    property p_thermal;
        @(posedge ref_clk) disable iff (!rstn)
        temp_s |=> out_enable == 4'h0;
    endproperty
    a_thermal: assert property (p_thermal) else $error("outputs on while over temperature");

    property p_timeout;
        @(posedge ref_clk) disable iff (!rstn)
        (state_reg != ST_IDLE && timeout) |=> (state_reg == ST_IDLE && edges_reg == 4'h0);
    endproperty
    a_timeout: assert property (p_timeout) else $error("silence did not end beep");

endmodule

// [shared/amp_mode_pkg.sv]
// shared constants and carrier types for the amplifier mode controller
package amp_mode_pkg;

    localparam int          CLK_FREQ_HZ          = 250_000_000;
    // beep qualification: rising edges needed before the beep path takes over
    localparam logic [3:0]  BEEP_MIN_EDGES       = 4'h8;
    // beep ends when no rising edge arrives within this time
    localparam int          BEEP_TIMEOUT_US      = 100;
    localparam int          BEEP_TIMEOUT_CYCLES  = (CLK_FREQ_HZ / 1_000_000) * BEEP_TIMEOUT_US;
    // fixed beep gain 0.3 V/V, expressed in tenths
    localparam logic [7:0]  BEEP_GAIN_TENTHS     = 8'h03;
    localparam logic [4:0]  VOLUME_RESET         = 5'h00;

    // input selector codes
    localparam logic [1:0]  SRC_NONE             = 2'h0;
    localparam logic [1:0]  SRC_LINE             = 2'h1;
    localparam logic [1:0]  SRC_HEADPHONE        = 2'h2;
    localparam logic [1:0]  SRC_BEEP             = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_COUNT = 3'b010,
        ST_BEEP  = 3'b100
    } beep_state_e;

    // output stage drive, one bit per amplifier
    typedef struct packed {
        logic left_noninverting_output;
        logic right_noninverting_output;
        logic left_inverting_output;
        logic right_inverting_output;
    } out_enable_s;

    // status register bits
    localparam int          IRQ_BEEP_START       = 0;
    localparam int          IRQ_BEEP_END         = 1;
    localparam int          IRQ_OVERTEMP         = 2;
    localparam int          IRQ_WIDTH            = 3;

    localparam logic [1:0]  ADDR_STATUS          = 2'h0;
    localparam logic [1:0]  ADDR_MASK            = 2'h1;
    localparam logic [1:0]  ADDR_MODE            = 2'h2;
    localparam logic [1:0]  ADDR_VOLUME          = 2'h3;
    localparam logic [2:0]  MASK_RESET           = 3'h0;

endpackage
